// [include/colc_pkg.sv]
// constants and types shared by the comparator output latch logic
package colc_pkg;

    // register byte addresses on the apb bus
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_MIRROR_GATE = 12'h000;
    localparam logic [11:0] OFF_LATCH_CTRL = 12'h004;

    // comparator_mirror_and_gate_ctrl field positions
    localparam int unsigned BIT_CMP1_MIRROR = 7;
    localparam int unsigned BIT_CMP2_MIRROR = 6;
    localparam int unsigned BIT_RSVD_HI = 5;
    localparam int unsigned BIT_RSVD_LO = 2;
    localparam int unsigned BIT_GATE_SEL = 1;
    localparam int unsigned BIT_SYNC_EN = 0;

    // latch_control_reg field positions
    localparam int unsigned BIT_CFG_HI = 7;
    localparam int unsigned BIT_CFG_LO = 6;
    localparam int unsigned BIT_PULSE_SET = 3;
    localparam int unsigned BIT_PULSE_RST = 2;

    // write data of both registers sits in byte lane 0
    localparam int unsigned LANE_LOW = 0;

    // reset values
    localparam logic RST_GATE_SEL = 1'b1;
    localparam logic RST_SYNC_EN = 1'b0;
    localparam logic [1:0] RST_OUT_CFG = 2'b00;
    localparam logic RST_LATCH = 1'b0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // software control state
    typedef struct packed {
        logic [1:0] out_cfg;
        logic gate_sel;
        logic sync_en;
    } colc_ctrl_s;

    localparam colc_ctrl_s CTRL_RESET = '{
        out_cfg: RST_OUT_CFG,
        gate_sel: RST_GATE_SEL,
        sync_en: RST_SYNC_EN
    };

    // levels forwarded to the port logic and the timer
    typedef struct packed {
        logic port1;
        logic port2;
        logic gate;
        logic latch_q;
    } colc_outs_s;

    localparam colc_outs_s OUTS_RESET = '{
        port1: 1'b0,
        port2: 1'b0,
        gate: 1'b0,
        latch_q: 1'b0
    };

endpackage : colc_pkg

// [verilog/colc_cmp2_sync.sv]
// comparator 2 synchroniser and timer-clock falling-edge capture
module colc_cmp2_sync (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmp2_raw_i,
    input wire logic timer_clk_i,
    input wire logic sync_en_i,
    output logic cmp2_level_o,
    output logic cmp2_synced_o
);

    logic cmp2_m_ff;
    logic cmp2_s_ff;
    logic tclk_m_ff;
    logic tclk_s_ff;
    logic tclk_d_ff;
    logic hold_ff;
    logic nxt_hold;
    wire logic tclk_fall;

    // edge seen on the second stage only; the first stage may be metastable
    assign tclk_fall = tclk_d_ff & ~tclk_s_ff;
    assign nxt_hold = tclk_fall ? cmp2_s_ff : hold_ff;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmp2_m_ff <= 1'b0;
            cmp2_s_ff <= 1'b0;
            tclk_m_ff <= 1'b0;
            tclk_s_ff <= 1'b0;
            tclk_d_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            cmp2_m_ff <= cmp2_raw_i;
            cmp2_s_ff <= cmp2_m_ff;
            tclk_m_ff <= timer_clk_i;
            tclk_s_ff <= tclk_m_ff;
            tclk_d_ff <= tclk_s_ff;
            hold_ff <= nxt_hold;
        end
    end

    assign cmp2_level_o = cmp2_s_ff;
    assign cmp2_synced_o = sync_en_i ? hold_ff : cmp2_s_ff;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_sync_capture: assert property (
        tclk_fall |=> (hold_ff == $past(cmp2_s_ff))
    ) else $error("cmp2 not captured on timer clock fall");

    a_sync_holds: assert property (
        (!tclk_fall && sync_en_i) |=> (!sync_en_i || $stable(cmp2_synced_o))
    ) else $error("synced cmp2 moved without timer clock fall");

endmodule : colc_cmp2_sync

// [verilog/colc_latch_logic.sv]
// comparator mirror, gate select, sr latch and output muxes with apb access
//
// The APB interface to the registers and the register addresses were decided locally.
module colc_latch_logic (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cmp1_output_i,
    input wire logic cmp2_output_i,
    input wire logic timer_clk_i,
    input wire logic timer_gate_pin_i,
    output logic timer_gate_o,
    output logic port_out1_o,
    output logic port_out2_o,
    output logic latch_q_o
);

    function automatic logic reg_hit(
        input logic [11:0] addr,
        input logic [11:0] off
    );
        reg_hit = (addr == off);
    endfunction : reg_hit

    colc_pkg::colc_ctrl_s ctrl_ff;
    colc_pkg::colc_ctrl_s nxt_ctrl;
    colc_pkg::colc_outs_s outs_ff;
    colc_pkg::colc_outs_s nxt_outs;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pulse_set_ff;
    logic pulse_rst_ff;
    logic latch_ff;
    logic cmp1_m_ff;
    logic cmp1_s_ff;
    logic gate_m_ff;
    logic gate_s_ff;
    logic cmp2_s;
    logic cmp2_synced;

    colc_cmp2_sync u_cmp2_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cmp2_raw_i(cmp2_output_i),
        .timer_clk_i(timer_clk_i),
        .sync_en_i(ctrl_ff.sync_en),
        .cmp2_level_o(cmp2_s),
        .cmp2_synced_o(cmp2_synced)
    );

    // bus decode
    wire logic hit_mirror;
    wire logic hit_latch;
    wire logic hit_any;
    wire logic setup_ph;
    wire logic access_ph;
    wire logic wr_ok;
    wire logic wr_mirror;
    wire logic wr_latch;

    assign hit_mirror = reg_hit(paddr_i, colc_pkg::OFF_MIRROR_GATE);
    assign hit_latch = reg_hit(paddr_i, colc_pkg::OFF_LATCH_CTRL);
    assign hit_any = hit_mirror | hit_latch;
    assign setup_ph = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    // only byte lane 0 holds writable bits
    assign wr_ok = access_ph & pwrite_i & pstrb_i[colc_pkg::LANE_LOW];
    assign wr_mirror = wr_ok & hit_mirror;
    assign wr_latch = wr_ok & hit_latch;

    // no wait state: read data is taken at the setup edge into a flop
    assign pready_o = access_ph;
    assign pslverr_o = access_ph & ~hit_any;
    assign prdata_o = prdata_ff;

    // read data assembly
    logic [31:0] rd_mirror;
    logic [31:0] rd_latch;

    always_comb begin
        rd_mirror = colc_pkg::RDATA_ZERO;
        // both bits taken from the same sampled pair
        rd_mirror[colc_pkg::BIT_CMP1_MIRROR] = cmp1_s_ff;
        rd_mirror[colc_pkg::BIT_CMP2_MIRROR] = cmp2_s;
        rd_mirror[colc_pkg::BIT_GATE_SEL] = ctrl_ff.gate_sel;
        rd_mirror[colc_pkg::BIT_SYNC_EN] = ctrl_ff.sync_en;
    end

    always_comb begin
        // pulse bits always read back zero
        rd_latch = colc_pkg::RDATA_ZERO;
        rd_latch[colc_pkg::BIT_CFG_HI] = ctrl_ff.out_cfg[1];
        rd_latch[colc_pkg::BIT_CFG_LO] = ctrl_ff.out_cfg[0];
    end

    // a read only loads prdata, nothing else reacts to it
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup_ph & ~pwrite_i & hit_mirror) begin
            nxt_prdata = rd_mirror;
        end else if (setup_ph & ~pwrite_i & hit_latch) begin
            nxt_prdata = rd_latch;
        end else if (setup_ph) begin
            nxt_prdata = colc_pkg::RDATA_ZERO;
        end
    end

    // control register writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        // only bits 1 and 0 are stored, bits 5..2 dropped
        if (wr_mirror) begin
            nxt_ctrl.gate_sel = pwdata_i[colc_pkg::BIT_GATE_SEL];
            nxt_ctrl.sync_en = pwdata_i[colc_pkg::BIT_SYNC_EN];
        end
        if (wr_latch) begin
            nxt_ctrl.out_cfg = {pwdata_i[colc_pkg::BIT_CFG_HI],
                                pwdata_i[colc_pkg::BIT_CFG_LO]};
        end
    end

    // the sr latch
    wire logic set_in;
    wire logic rst_in;

    // set from comparator 1 or software pulse
    assign set_in = cmp1_s_ff | pulse_set_ff;
    // reset from comparator 2 or software pulse
    assign rst_in = cmp2_s | pulse_rst_ff;

    // level-sensitive on purpose: set and reset act at once, no clock
    // edge in the path; set_in and rst_in are flop outputs, so input glitches are sampled before they reach the state
    // unclocked set/reset latch
    always_latch begin
        if (rst_i) begin
            latch_ff <= colc_pkg::RST_LATCH;
        end else if (rst_in) begin
            latch_ff <= 1'b0;
        end else if (set_in) begin
            latch_ff <= 1'b1;
        end
    end

    // output selection
    always_comb begin
        // latch or raw comparator per port path
        // low bit q on path 1, high bit inverted q on path 2
        nxt_outs.port1 = ctrl_ff.out_cfg[0] ? latch_ff : cmp1_s_ff;
        nxt_outs.port2 = ctrl_ff.out_cfg[1] ? ~latch_ff : cmp2_s;
        // gate pin when set, synced comparator 2 when clear
        nxt_outs.gate = ctrl_ff.gate_sel ? gate_s_ff : cmp2_synced;
        nxt_outs.latch_q = latch_ff;
    end

    assign port_out1_o = outs_ff.port1;
    assign port_out2_o = outs_ff.port2;
    assign timer_gate_o = outs_ff.gate;
    assign latch_q_o = outs_ff.latch_q;

    // pins from outside pass two flops before use
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmp1_m_ff <= 1'b0;
            cmp1_s_ff <= 1'b0;
            gate_m_ff <= 1'b0;
            gate_s_ff <= 1'b0;
        end else begin
            cmp1_m_ff <= cmp1_output_i;
            cmp1_s_ff <= cmp1_m_ff;
            gate_m_ff <= timer_gate_pin_i;
            gate_s_ff <= gate_m_ff;
        end
    end

    // pulse lasts exactly one clock after the write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pulse_set_ff <= 1'b0;
            pulse_rst_ff <= 1'b0;
        end else begin
            pulse_set_ff <= wr_latch & pwdata_i[colc_pkg::BIT_PULSE_SET];
            pulse_rst_ff <= wr_latch & pwdata_i[colc_pkg::BIT_PULSE_RST];
        end
    end

    // raw comparator paths and gate pin after reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_ff <= colc_pkg::CTRL_RESET;
            outs_ff <= colc_pkg::OUTS_RESET;
            prdata_ff <= colc_pkg::RDATA_ZERO;
        end else begin
            ctrl_ff <= nxt_ctrl;
            outs_ff <= nxt_outs;
            prdata_ff <= nxt_prdata;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_mirror_read: assert property (
        (setup_ph && !pwrite_i && hit_mirror) |=>
            (prdata_o[colc_pkg::BIT_CMP1_MIRROR] == $past(cmp1_s_ff)) &&
            (prdata_o[colc_pkg::BIT_CMP2_MIRROR] == $past(cmp2_s))
    ) else $error("mirror bits do not match comparator levels");

    a_rsvd_zero: assert property (
        (pready_o && hit_mirror && !pwrite_i) |->
            (prdata_o[colc_pkg::BIT_RSVD_HI:colc_pkg::BIT_RSVD_LO] == 4'h0)
    ) else $error("reserved bits read non-zero");

    a_gate_pin_route: assert property (
        (ctrl_ff.gate_sel && gate_s_ff) |=> timer_gate_o
    ) else $error("gate pin not routed to timer gate");

    a_gate_cmp_route: assert property (
        (!ctrl_ff.gate_sel && !cmp2_synced) |=> !timer_gate_o
    ) else $error("synced comparator 2 not routed to timer gate");

    a_latch_set: assert property (
        (set_in && !rst_in) |-> latch_ff
    ) else $error("latch not set");

    a_latch_reset: assert property (
        (rst_in && !set_in) |-> !latch_ff
    ) else $error("latch not reset");

    a_latch_dominant: assert property (
        (rst_in && set_in) |-> !latch_ff
    ) else $error("reset did not dominate");

    a_latch_idle: assert property (
        (!set_in && !rst_in) |-> $stable(latch_ff)
    ) else $error("latch moved with idle inputs");

    a_pulse_once: assert property (
        (wr_latch && pwdata_i[colc_pkg::BIT_PULSE_SET]) |=>
            pulse_set_ff ##1 !pulse_set_ff
    ) else $error("set pulse not exactly one clock");

    a_pulse_read_zero: assert property (
        (pready_o && hit_latch && !pwrite_i) |->
            !prdata_o[colc_pkg::BIT_PULSE_SET] &&
            !prdata_o[colc_pkg::BIT_PULSE_RST]
    ) else $error("pulse bit read back non-zero");

    a_port_mux: assert property (
        ctrl_ff.out_cfg[1] |=> (port_out2_o == !$past(latch_ff))
    ) else $error("path 2 not inverted latch output");

    a_reset_default: assert property (
        disable iff (1'b0) rst_i |=> (ctrl_ff == colc_pkg::CTRL_RESET)
    ) else $error("control not at reset default");

    a_pulse_rst_once: assert property (
        (wr_latch && pwdata_i[colc_pkg::BIT_PULSE_RST]) |=>
            pulse_rst_ff ##1 !pulse_rst_ff
    ) else $error("reset pulse not exactly one clock");

    a_path1_latch: assert property (
        ctrl_ff.out_cfg[0] |=> (port_out1_o == $past(latch_ff))
    ) else $error("path 1 not latch output");

    a_path1_raw: assert property (
        !ctrl_ff.out_cfg[0] |=> (port_out1_o == $past(cmp1_s_ff))
    ) else $error("path 1 not raw comparator 1");

    a_path2_raw: assert property (
        !ctrl_ff.out_cfg[1] |=> (port_out2_o == $past(cmp2_s))
    ) else $error("path 2 not raw comparator 2");

    a_read_no_effect: assert property (
        (psel_i && !pwrite_i) |=> $stable(ctrl_ff) && !pulse_set_ff &&
            !pulse_rst_ff
    ) else $error("register read changed control state");

endmodule : colc_latch_logic

// [dv/colc_far_model.sv]
// far side: prescaled timer clock source and external gate pin
module colc_far_model (
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire logic gate_lvl_i,
    output logic timer_clk_o,
    output logic gate_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_ff = 3'h0;
    // prescaled clock, stands low between bursts
    always_ff @(posedge core_clk_i) begin
        div_ff <= run_i ? div_ff + 3'h1 : 3'h0;
    end
    assign timer_clk_o = run_i & div_ff[2];
    assign gate_pin_o = gate_lvl_i;
endmodule : colc_far_model

// [dv/tb_colc_latch_logic.sv]
// self-checking bench for the comparator output latch logic
module tb_colc_latch_logic;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] MG = colc_pkg::OFF_MIRROR_GATE;
    localparam logic [11:0] LC = colc_pkg::OFF_LATCH_CTRL;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic c1, c2, tclk, gpin, run, glvl, gate, p1, p2, q, mq;
    logic [1:0] cfg;
    logic [2:0] ex;
    int fails, cmp_count;

    colc_latch_logic u_dut (.core_clk_i(clk), .rst_i(rst), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp1_output_i(c1),
        .cmp2_output_i(c2), .timer_clk_i(tclk), .timer_gate_pin_i(gpin),
        .timer_gate_o(gate), .port_out1_o(p1), .port_out2_o(p2),
        .latch_q_o(q));
    colc_far_model u_far (.core_clk_i(clk), .run_i(run), .gate_lvl_i(glvl),
        .timer_clk_o(tclk), .gate_pin_o(gpin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] mir(input logic a, b, gs, se);
        return {24'h000000, a, b, 4'h0, gs, se};
    endfunction : mir

    // timer clock burst long enough for several falling edges
    task automatic tick;
        run <= 1'b1;
        wt(40);
        run <= 1'b0;
        wt(6);
    endtask : tick

    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        wt(20000);
        fails++;
        results();
    end

    initial begin
        {psel, penable, pwrite, c1, c2, run, glvl, mq} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        cfg = 2'b00;
        fails = 0;
        cmp_count = 0;
        rst = 1'b1;
        void'($urandom(53888));
        wt(12);
        rst <= 1'b0;
        apb(1'b0, MG, 32'h0);
        chk(rd, mir(1'b0, 1'b0, 1'b1, 1'b0));
        apb(1'b0, LC, 32'h0);
        chk(rd, 32'h0);
        chk(32'({q, p1, p2, gate}), 32'h0);
        apb(1'b1, MG, 32'hFF);
        apb(1'b0, MG, 32'h0);
        chk(rd, mir(1'b0, 1'b0, 1'b1, 1'b1));
        apb(1'b1, MG, 32'h02);
        apb(1'b1, LC, 32'h33);
        apb(1'b0, LC, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0); // unmapped address reads zero
        chk(32'(err), 32'h1); // unmapped address refused
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            cfg = 2'($urandom);
            apb(1'b1, LC, {24'h0, cfg, 6'h00});
            @(posedge clk);
            c1 <= 1'($urandom);
            c2 <= 1'($urandom);
            wt(8);
            mq = c2 ? 1'b0 : (c1 ? 1'b1 : mq);
            ex = {mq, cfg[0] ? mq : c1, cfg[1] ? ~mq : c2};
            chk(32'({q, p1, p2}), 32'(ex));
            apb(1'b0, MG, 32'h0);
            chk(rd, mir(c1, c2, 1'b1, 1'b0));
        end
        $display("test random latch done");
        cfg = 2'b11;
        @(posedge clk);
        c1 <= 1'b0;
        c2 <= 1'b0;
        apb(1'b1, LC, {24'h0, cfg, 6'h04});
        wt(8);
        chk(32'(q), 32'h0);
        apb(1'b1, LC, {24'h0, cfg, 6'h08});
        wt(6);
        chk(32'({q, p1, p2}), 32'h6);
        apb(1'b0, LC, 32'h0);
        chk(rd, {24'h0, cfg, 6'h00});
        @(posedge clk);
        c2 <= 1'b1;
        wt(8);
        chk(32'(q), 32'h0);
        apb(1'b1, LC, {24'h0, cfg, 6'h08});
        wt(6);
        chk(32'(q), 32'h0);
        @(posedge clk);
        c1 <= 1'b1;
        wt(8);
        chk(32'(q), 32'h0);
        @(posedge clk);
        c2 <= 1'b0;
        wt(8);
        chk(32'(q), 32'h1);
        @(posedge clk);
        c1 <= 1'b0;
        apb(1'b1, LC, {24'h0, cfg, 6'h04});
        wt(6);
        chk(32'({q, p1, p2}), 32'h1);
        $display("test pulses done");
        @(posedge clk);
        glvl <= 1'b1;
        wt(6);
        chk(32'(gate), 32'h1);
        apb(1'b1, MG, 32'h00);
        wt(6);
        chk(32'(gate), 32'h0);
        @(posedge clk);
        c2 <= 1'b1;
        wt(6);
        chk(32'(gate), 32'h1);
        apb(1'b1, MG, 32'h01);
        tick();
        chk(32'(gate), 32'h1);
        @(posedge clk);
        c2 <= 1'b0;
        wt(10);
        chk(32'(gate), 32'h1);
        tick();
        chk(32'(gate), 32'h0);
        $display("test gate done");
        @(posedge clk);
        rst <= 1'b1;
        c1 <= 1'b1;
        c2 <= 1'b1;
        wt(2);
        rst <= 1'b0;
        apb(1'b0, LC, 32'h0);
        chk(rd, 32'h0);
        wt(4);
        chk(32'({p1, p2, gate}), 32'({c1, c2, glvl}));
        apb(1'b0, MG, 32'h0);
        chk(rd, mir(c1, c2, 1'b1, 1'b0));
        $display("test second reset done");
        results();
    end
endmodule : tb_colc_latch_logic
